/* File: ippu_pkg.sv */
// shared constants, types and decoders of the parallel poll unit
package ippu_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] ADDR_AUXCMD = 8'h00;
	localparam logic [7:0] ADDR_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_AUXB   = 8'h08;
	localparam logic [7:0] ADDR_PASS_THRU = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;

	// auxiliary command codes written to the command register
	localparam logic [7:0] AUX_EXEC_POLL = 8'h01;
	localparam logic [7:0] AUX_SET_FLAG  = 8'h02;
	localparam logic [7:0] AUX_CLR_FLAG  = 8'h03;

	// poll configuration register fields
	localparam int CFG_LINE_LSB    = 0;
	localparam int CFG_SENSE_BIT   = 3;
	localparam int CFG_DISABLE_BIT = 4;
	localparam int CFG_REMOTE_BIT  = 5;
	localparam logic [7:0] CFG_RESET = 8'h10;

	// aux mode register b and status register fields
	localparam int AUXB_SRC_BIT = 0;
	localparam int ST_DONE_BIT  = 0;
	localparam int ST_RPP_BIT   = 1;
	localparam int ST_IST_BIT   = 2;
	localparam int ST_IDY_BIT   = 3;

	// bus command bytes, parity bit ignored
	localparam logic [6:0] BUS_PPC  = 7'h05;
	localparam logic [6:0] BUS_PPU  = 7'h15;
	localparam logic [6:0] BUS_PPD  = 7'h70;
	localparam logic [2:0] BUS_PPE_HI = 3'b110;

	// identify time during an executed poll
	localparam int CLK_NS   = 20;
	localparam int POLL_NS  = 2000;
	localparam int POLL_CYC = (POLL_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_IDY  = 2'b01,
		ST_CAPT = 2'b11
	} ippu_state_t;

	// enable byte: x110 sppp
	function automatic logic ippu_is_ppe(input logic [7:0] b);
		return b[6:4] == BUS_PPE_HI;
	endfunction : ippu_is_ppe

	// secondary group: enable and disable bytes
	function automatic logic ippu_is_secondary(input logic [7:0] b);
		return b[6:5] == 2'b11;
	endfunction : ippu_is_secondary

endpackage : ippu_pkg

/* File: ippu_resp_if.sv */
// carries poll configuration and status from control to responder
`timescale 1ns/1ps
interface ippu_resp_if;
	logic       enable;
	logic       sense;
	logic [2:0] line;
	logic       ist;
	logic       idy;
	modport src  (output enable, output sense, output line, output ist,
		output idy);
	modport resp (input enable, input sense, input line, input ist,
		input idy);
endinterface : ippu_resp_if

/* File: ippu_responder.sv */
// drives the parallel poll response onto the open-collector data lines
`timescale 1ns/1ps
module ippu_responder
	import ippu_pkg::*;
#(
	parameter int DIO_W = 8
) (
	input  wire logic             clk_in,
	input  wire logic             reset_n_in,
	ippu_resp_if.resp             cfg,
	output logic     [DIO_W-1:0]  dio_out,
	output logic     [DIO_W-1:0]  dio_oe_out
);

	if (DIO_W != 8) begin : g_bad_width
		$error("responder serves exactly eight data lines");
	end

	// true level when status matches sense; lines only ever pulled true
	logic answer_true;
	assign answer_true = cfg.enable & cfg.idy & (cfg.ist == cfg.sense);

	// open collector: false is released, so one true line wins
	assign dio_out = '1;

	// one decoded line per response, remaining lines left passive
	for (genvar i = 0; i < DIO_W; i++) begin : g_line
		assign dio_oe_out[i] = answer_true &&
			(cfg.line == 3'(i));
	end

	a_one_line_only: assert property (@(posedge clk_in)
		disable iff (!reset_n_in) $onehot0(dio_oe_out))
		else $error("more than one poll line driven");
	a_release_on_idy: assert property (@(posedge clk_in)
		disable iff (!reset_n_in) !cfg.idy |-> dio_oe_out == '0)
		else $error("poll line driven without identify");

endmodule : ippu_responder

/* File: ippu_top.sv */
// parallel poll unit: controller poll, configuration, status, bus slave
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module ippu_top
	import ippu_pkg::*;
#(
	parameter int DIO_W    = 8,
	parameter int POLL_LEN = POLL_CYC
) (
	input  wire logic             clk_in,
	input  wire logic             reset_n_in,
	input  wire logic             hsel_in,
	input  wire logic [31:0]      haddr_in,
	input  wire logic [1:0]       htrans_in,
	input  wire logic             hwrite_in,
	input  wire logic [2:0]       hsize_in,
	input  wire logic             hready_in,
	input  wire logic [31:0]      hwdata_in,
	output logic      [31:0]      hrdata_out,
	output logic                  hreadyout_out,
	output logic                  hresp_out,
	input  wire logic             ctrl_active_in,
	input  wire logic             ctrl_wait_in,
	input  wire logic             cmd_sent_in,
	input  wire logic             cmd_valid_in,
	input  wire logic [7:0]       cmd_byte_in,
	input  wire logic             listen_addr_in,
	input  wire logic             srqs_in,
	input  wire logic             srq_drive_in,
	input  wire logic             idy_in,
	input  wire logic [DIO_W-1:0] dio_in,
	output logic      [DIO_W-1:0] dio_out,
	output logic      [DIO_W-1:0] dio_oe_out,
	output logic                  idy_out,
	output logic                  command_out_ready_out
);

	if (DIO_W != 8 || POLL_LEN < 1 || POLL_LEN > 255) begin : g_bad_par
		$error("unit needs eight data lines and a poll length of 1..255");
	end

	ippu_state_t state;
	ippu_state_t next_state;
	logic [7:0]  poll_cnt;
	logic        rpp;
	logic        ist_flag;
	logic        ist;
	logic        command_out_ready;
	logic [7:0]  command_pass_through_reg;
	logic [7:0]  aux_mode_reg_b;
	logic        status_source_select;
	logic        cfg_disable;
	logic        cfg_sense;
	logic [2:0]  response_line_select;
	logic        cfg_remote;
	logic        ppc_armed;
	logic        poll_done;

	// bus phase tracking
	logic        acc_wr;
	logic [7:0]  acc_addr;
	logic        addr_ok;
	logic        rd_now;
	logic        wr_hit;
	logic [7:0]  wr_byte;
	logic [7:0]  poll_config_register;
	logic [7:0]  status_byte;

	ippu_resp_if rif ();

	// ---------------------------------------------------------------
	// bus slave: never stalls, always answers okay
	// ---------------------------------------------------------------
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;
	assign addr_ok       = hsel_in && hready_in && htrans_in[1];
	assign rd_now        = addr_ok && !hwrite_in;
	assign wr_hit        = acc_wr;
	assign wr_byte       = hwdata_in[7:0];

	// address phase of a write is held for its data phase
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			acc_wr   <= 1'b0;
			acc_addr <= 8'h00;
		end else begin
			acc_wr   <= addr_ok && hwrite_in;
			acc_addr <= haddr_in[7:0];
		end
	end

	// read views of the registers
	assign poll_config_register = {2'b00, cfg_remote, cfg_disable,
		cfg_sense, response_line_select};
	always_comb begin
		status_byte              = 8'h00;
		status_byte[ST_DONE_BIT] = command_out_ready;
		status_byte[ST_RPP_BIT]  = rpp;
		status_byte[ST_IST_BIT]  = ist;
		status_byte[ST_IDY_BIT]  = idy_out;
	end

	// read data registered at the address phase so it stands in data phase
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			hrdata_out <= 32'h0000_0000;
		end else if (rd_now) begin
			case (haddr_in[7:0])
				ADDR_CONFIG: hrdata_out <= {24'h0, poll_config_register};
				ADDR_AUXB:   hrdata_out <= {24'h0, aux_mode_reg_b};
				ADDR_PASS_THRU: hrdata_out <= {24'h0, command_pass_through_reg};
				ADDR_STATUS: hrdata_out <= {24'h0, status_byte};
				default:     hrdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// software commands decoded in the write data phase
	logic aux_wr;
	logic exec_cmd;
	logic set_cmd;
	logic clr_cmd;
	assign aux_wr   = wr_hit && acc_addr == ADDR_AUXCMD;
	assign exec_cmd = aux_wr && wr_byte == AUX_EXEC_POLL;
	assign set_cmd  = aux_wr && wr_byte == AUX_SET_FLAG;
	assign clr_cmd  = aux_wr && wr_byte == AUX_CLR_FLAG;

	// aux mode register b, only the source select bit is kept
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			aux_mode_reg_b <= 8'h00;
		end else if (wr_hit && acc_addr == ADDR_AUXB) begin
			aux_mode_reg_b <= {7'h00, wr_byte[AUXB_SRC_BIT]};
		end
	end
	assign status_source_select = aux_mode_reg_b[AUXB_SRC_BIT];

	// ---------------------------------------------------------------
	// individual status
	// ---------------------------------------------------------------
	// flag moves only on its two commands; set wins if both arrive
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			ist_flag <= 1'b0;
		end else if (!status_source_select && set_cmd) begin
			ist_flag <= 1'b1;
		end else if (!status_source_select && clr_cmd) begin
			ist_flag <= 1'b0;
		end
	end

	// source select ties status to the service request function
	assign ist = status_source_select ? (srqs_in && srq_drive_in)
		: ist_flag;

	// ---------------------------------------------------------------
	// configuration: local writes or remote commands
	// ---------------------------------------------------------------
	logic cfg_wr;
	logic remote_byte;
	assign cfg_wr      = wr_hit && acc_addr == ADDR_CONFIG;
	assign remote_byte = cmd_valid_in && cfg_remote;

	// configure command arms the secondary decode while listen-addressed
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			ppc_armed <= 1'b0;
		end else if (remote_byte) begin
			ppc_armed <= (cmd_byte_in[6:0] == BUS_PPC && listen_addr_in) ||
				(ppc_armed && ippu_is_secondary(cmd_byte_in));
		end
	end

	// the mode bit is always writable; fields only from the active source
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			cfg_remote           <= CFG_RESET[CFG_REMOTE_BIT];
			cfg_disable          <= CFG_RESET[CFG_DISABLE_BIT];
			cfg_sense            <= CFG_RESET[CFG_SENSE_BIT];
			response_line_select <= CFG_RESET[CFG_LINE_LSB +: 3];
		end else begin
			if (cfg_wr) begin
				cfg_remote <= wr_byte[CFG_REMOTE_BIT];
			end
			if (cfg_wr && !cfg_remote) begin
				cfg_disable          <= wr_byte[CFG_DISABLE_BIT];
				cfg_sense            <= wr_byte[CFG_SENSE_BIT];
				response_line_select <= wr_byte[CFG_LINE_LSB +: 3];
			end else if (remote_byte && ppc_armed &&
					ippu_is_ppe(cmd_byte_in)) begin
				cfg_disable          <= 1'b0;
				cfg_sense            <= cmd_byte_in[3];
				response_line_select <= cmd_byte_in[2:0];
			end else if (remote_byte && ((ppc_armed &&
					cmd_byte_in[6:0] == BUS_PPD) ||
					cmd_byte_in[6:0] == BUS_PPU)) begin
				cfg_disable <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// executed poll as active controller
	// ---------------------------------------------------------------
	// request local message: set by command, cleared once captured
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			rpp <= 1'b0;
		end else if (exec_cmd) begin
			rpp <= 1'b1;
		end else if (state == ST_IDY && poll_cnt == 8'h00 &&
				ctrl_active_in) begin
			rpp <= 1'b0; // aborted poll keeps its request
		end
	end

	// identify waits for the controller active and wait states together
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (rpp && ctrl_active_in && ctrl_wait_in) begin
					next_state = ST_IDY;
				end
			end
			ST_IDY: begin
				if (!ctrl_active_in) begin
					next_state = ST_IDLE;
				end else if (poll_cnt == 8'h00) begin
					next_state = ST_CAPT;
				end
			end
			ST_CAPT: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// identify time counter, reloaded in every idle cycle
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			poll_cnt <= 8'h00;
		end else if (state == ST_IDLE) begin
			poll_cnt <= 8'(POLL_LEN - 1);
		end else if (state == ST_IDY && poll_cnt != 8'h00) begin
			poll_cnt <= poll_cnt - 8'h01;
		end
	end

	assign idy_out   = state == ST_IDY;
	assign poll_done = state == ST_CAPT;

	// capture in the last identify cycle, so lines have settled longest
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			command_pass_through_reg <= 8'h00;
		end else if (!ctrl_active_in || cmd_sent_in) begin
			command_pass_through_reg <= 8'h00;
		end else if (state == ST_IDY && poll_cnt == 8'h00) begin
			command_pass_through_reg <= dio_in;
		end
	end

	// completion flag; a new completion beats a status read clear
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			command_out_ready <= 1'b0;
		end else if (poll_done) begin
			command_out_ready <= 1'b1;
		end else if (exec_cmd || (rd_now && haddr_in[7:0] == ADDR_STATUS)) begin
			command_out_ready <= 1'b0;
		end
	end
	assign command_out_ready_out = command_out_ready;

	// ---------------------------------------------------------------
	// responder; own identify also answers so the captured byte is full
	// ---------------------------------------------------------------
	assign rif.enable = !cfg_disable;
	assign rif.sense  = cfg_sense;
	assign rif.line   = response_line_select;
	assign rif.ist    = ist;
	assign rif.idy    = idy_in || idy_out;

	ippu_responder #(
		.DIO_W (DIO_W)
	) u_resp (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.cfg        (rif),
		.dio_out    (dio_out),
		.dio_oe_out (dio_oe_out)
	);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	a_idy_start: assert property (
		state == ST_IDLE && rpp && ctrl_active_in && ctrl_wait_in
		|=> idy_out)
		else $error("identify not raised for pending poll");
	a_idy_length: assert property (
		$rose(idy_out) && ctrl_active_in |-> idy_out[*2] ##[0:300] !idy_out)
		else $error("identify time out of bounds");
	a_capture_byte: assert property (
		state == ST_IDY && poll_cnt == 8'h00 && ctrl_active_in &&
		!cmd_sent_in |=> command_pass_through_reg == $past(dio_in) && !rpp)
		else $error("poll response not captured");
	a_done_flag: assert property (
		state == ST_IDY && poll_cnt == 8'h00 && ctrl_active_in
		|=> ##1 command_out_ready_out)
		else $error("completion flag not set after poll");
	a_command_pass_through_reg_holds: assert property (
		state == ST_IDLE && ctrl_active_in && !cmd_sent_in
		|=> $stable(command_pass_through_reg))
		else $error("captured response lost");
	a_command_pass_through_reg_drops: assert property (
		!ctrl_active_in |=> command_pass_through_reg == 8'h00)
		else $error("captured response outlived control");
	a_local_static: assert property (
		!cfg_remote && !cfg_wr |=> $stable(poll_config_register[4:0]))
		else $error("local configuration changed without write");
	a_remote_enable: assert property (
		remote_byte && ppc_armed && ippu_is_ppe(cmd_byte_in) && !cfg_wr
		|=> !cfg_disable && response_line_select == $past(cmd_byte_in[2:0]))
		else $error("enable command not applied");
	a_flag_only_cmd: assert property (
		!status_source_select && !set_cmd && !clr_cmd |=> $stable(ist_flag))
		else $error("status flag moved without command");
	a_srq_status: assert property (
		status_source_select && !cfg_disable && rif.idy &&
		cfg_sense && srqs_in && srq_drive_in
		|-> dio_oe_out[response_line_select])
		else $error("service request status not answered");

	c_poll_done: cover property (poll_done);
	c_remote_cfg: cover property (remote_byte && ppc_armed &&
		ippu_is_ppe(cmd_byte_in));
	c_srq_answer: cover property (status_source_select && idy_out &&
		dio_oe_out != '0);

endmodule : ippu_top

/* File: ippu_far_model.sv */
// far-side model: other instruments and the controller in charge
`timescale 1ns/1ps
module ippu_far_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] dio_oe_in,
	input  wire logic [7:0] dio_lvl_in,
	output logic      [7:0] dio_wire_out,
	output logic            idy_out,
	output logic            cmd_valid_out,
	output logic      [7:0] cmd_byte_out,
	output logic            listen_out
);
	logic [7:0] pull;

	// wired line: any device pulling true beats passive false
	assign dio_wire_out = pull | (dio_oe_in & dio_lvl_in);

	initial begin
		pull = 8'h00;
		idy_out = 1'b0;
		cmd_valid_out = 1'b0;
		cmd_byte_out = 8'h00;
		listen_out = 1'b0;
	end

	// other devices' own responses; released lines float passive false
	task set_pull(input logic [7:0] p);
		pull <= p;
	endtask : set_pull

	// one byte per pulse; the byte lines show garbage once released
	task send(input logic [7:0] b);
		cmd_byte_out <= b;
		cmd_valid_out <= 1'b1;
		@(posedge clk_in);
		cmd_valid_out <= 1'b0;
		cmd_byte_out <= ~b;
		@(posedge clk_in);
	endtask : send

	// unlisten all, optionally address the unit, configure, then the byte
	task setup(input logic [7:0] b, input logic addr);
		send(8'h3f);
		listen_out <= 1'b0;
		if (addr) begin
			send(8'h21);
			listen_out <= 1'b1;
		end
		send(8'h05);
		send(b);
	endtask : setup

	// identify from another controller; enables seen during and after
	task poll(output logic [7:0] s1, output logic [7:0] s2);
		idy_out <= 1'b1;
		@(posedge clk_in);
		@(posedge clk_in);
		s1 = dio_oe_in;
		idy_out <= 1'b0;
		@(posedge clk_in);
		@(posedge clk_in);
		s2 = dio_oe_in;
	endtask : poll
endmodule : ippu_far_model

/* File: tb.sv */
// self-checking bench of the parallel poll unit
`timescale 1ns/1ps
module tb;
	import ippu_pkg::*;
	localparam int PL = 3;
	logic        clk, rst_n, hsel, hwr, rd_ph, hrdy, hresp;
	logic        act, cwait, csent, srqs, srqd, idy_o, co;
	logic        f_idy, f_cv, f_lis, ist;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic [7:0]  dio, dio_d, oe, f_cb, p, s1, s2;
	int          fails, n_tests, cyc, seed, k;
	logic [31:0] rd_q[$];

	ippu_top #(.POLL_LEN(PL)) ippu_top_i (.clk_in(clk), .reset_n_in(rst_n),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwr), .hsize_in(3'b010), .hready_in(hrdy),
		.hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hrdy),
		.hresp_out(hresp), .ctrl_active_in(act), .ctrl_wait_in(cwait),
		.cmd_sent_in(csent), .cmd_valid_in(f_cv), .cmd_byte_in(f_cb),
		.listen_addr_in(f_lis), .srqs_in(srqs), .srq_drive_in(srqd),
		.idy_in(f_idy), .dio_in(dio), .dio_out(dio_d), .dio_oe_out(oe),
		.idy_out(idy_o), .command_out_ready_out(co));
	ippu_far_model ippu_far_model_i (.clk_in(clk), .dio_oe_in(oe),
		.dio_lvl_in(dio_d),
		.dio_wire_out(dio), .idy_out(f_idy), .cmd_valid_out(f_cv),
		.cmd_byte_out(f_cb), .listen_out(f_lis));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	// oldest read note against the data phase just ended
	always @(posedge clk) begin
		if (rd_ph === 1'b1 && hrdy === 1'b1) begin
			chk(hrdata, rd_q.pop_front());
			chk(hresp, 1'b0);
		end
	end

	// a hang is cut short well past the few hundred cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			end_sim();
		end
	end

	// single word transfer; waits on hready in both phases
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwr <= w;
		htrans <= 2'b10;
		do @(posedge clk); while (hrdy !== 1'b1);
		htrans <= 2'b00;
		hwdata <= w ? d : 32'h0;
		rd_ph <= !w;
		do @(posedge clk); while (hrdy !== 1'b1);
		rd_ph <= 1'b0;
	endtask : bus

	task wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d});
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] e);
		rd_q.push_back({24'h0, e});
		bus(1'b0, a, 32'h0);
	endtask : rd

	// execute a poll and count the identify cycles
	task run_poll;
		wr(ADDR_AUXCMD, AUX_EXEC_POLL);
		cwait <= 1'b1;
		k = 0;
		while (idy_o !== 1'b1 && k < 20) begin
			@(posedge clk);
			k++;
		end
		k = 0;
		while (idy_o === 1'b1 && k < 50) begin
			@(posedge clk);
			k++;
		end
		cwait <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : run_poll

	initial begin
		seed = 32'h7673367e;
		{rst_n, hsel, hwr, rd_ph, act, cwait, csent, srqs, srqd} = 9'h0;
		htrans = 2'b00;
		haddr = 32'h0;
		hwdata = 32'h0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk(idy_o, 1'b0);
		rd(ADDR_CONFIG, CFG_RESET);
		rd(ADDR_STATUS, 8'h00);
		rd(ADDR_PASS_THRU, 8'h00);
		rd(ADDR_AUXB, 8'h00);
		rd(8'h14, 8'h00);
		ippu_far_model_i.poll(s1, s2);
		chk(s1, 8'h00);
		$display("test reset done");
		// all sixteen line and sense pairs with a random status
		for (int i = 0; i < 16; i++) begin
			ist = 1'($random(seed));
			wr(ADDR_AUXCMD, ist ? AUX_SET_FLAG : AUX_CLR_FLAG);
			wr(ADDR_CONFIG, 8'(i));
			rd(ADDR_STATUS, {5'h0, ist, 2'b00});
			ippu_far_model_i.poll(s1, s2);
			chk(s1, (ist == i[3]) ? 8'h01 << i[2:0] : 8'h00);
			chk(s2, 8'h00);
		end
		wr(ADDR_CONFIG, 8'h1f);
		ippu_far_model_i.poll(s1, s2);
		chk(s1, 8'h00);
		$display("test local done");
		// status taken from service request, flag commands ignored
		wr(ADDR_AUXCMD, AUX_CLR_FLAG);
		wr(ADDR_AUXB, 8'h01);
		wr(ADDR_CONFIG, 8'h08);
		for (int j = 0; j < 4; j++) begin
			srqs <= j[0];
			srqd <= j[1];
			wr(ADDR_AUXCMD, AUX_SET_FLAG);
			rd(ADDR_STATUS, (j == 3) ? 8'h04 : 8'h00);
			ippu_far_model_i.poll(s1, s2);
			chk(s1, (j == 3) ? 8'h01 : 8'h00);
		end
		wr(ADDR_AUXB, 8'h00);
		{srqs, srqd} <= 2'b00;
		rd(ADDR_STATUS, 8'h00);
		$display("test source done");
		// executed poll; own response joins the others on the wire
		wr(ADDR_CONFIG, 8'h0d);
		wr(ADDR_AUXCMD, AUX_SET_FLAG);
		p = 8'($random(seed));
		ippu_far_model_i.set_pull(p);
		act <= 1'b1;
		wr(ADDR_AUXCMD, AUX_EXEC_POLL);
		rd(ADDR_STATUS, 8'h06);
		chk(idy_o, 1'b0);
		run_poll();
		chk(k, PL);
		chk(co, 1'b1);
		rd(ADDR_STATUS, 8'h05);
		rd(ADDR_PASS_THRU, p | 8'h20);
		rd(ADDR_STATUS, 8'h04);
		rd(ADDR_PASS_THRU, p | 8'h20);
		csent <= 1'b1;
		@(posedge clk);
		csent <= 1'b0;
		rd(ADDR_PASS_THRU, 8'h00);
		p = 8'($random(seed));
		ippu_far_model_i.set_pull(p);
		run_poll();
		rd(ADDR_PASS_THRU, p | 8'h20);
		act <= 1'b0;
		@(posedge clk);
		rd(ADDR_PASS_THRU, 8'h00);
		ippu_far_model_i.set_pull(8'h00);
		$display("test poll done");
		// remote enable, blocked local write, unaddressed and disable
		wr(ADDR_CONFIG, 8'h30);
		ippu_far_model_i.setup(8'h6b, 1'b1);
		rd(ADDR_CONFIG, 8'h2b);
		ippu_far_model_i.poll(s1, s2);
		chk(s1, 8'h08);
		wr(ADDR_CONFIG, 8'h21);
		rd(ADDR_CONFIG, 8'h2b);
		wr(ADDR_AUXCMD, AUX_CLR_FLAG);
		ippu_far_model_i.poll(s1, s2);
		chk(s1, 8'h00);
		wr(ADDR_AUXCMD, AUX_SET_FLAG);
		ippu_far_model_i.setup(8'h64, 1'b0);
		rd(ADDR_CONFIG, 8'h2b);
		ippu_far_model_i.setup(8'h70, 1'b1);
		ippu_far_model_i.poll(s1, s2);
		chk(s1, 8'h00);
		rd(ADDR_CONFIG, 8'h3b);
		ippu_far_model_i.setup(8'h6b, 1'b1);
		rd(ADDR_CONFIG, 8'h2b);
		ippu_far_model_i.send(8'h15);
		rd(ADDR_CONFIG, 8'h3b);
		$display("test remote done");
		end_sim();
	end
endmodule : tb
